// >>> hdl/efs_pkg.sv
// package for the enclosure fault signal block
// assumes a 40 MHz system clock
package efs_pkg;

  // ****************************************
  // timing
  // ****************************************
  localparam int unsigned CLK_HZ          = 40000000;
  localparam int unsigned POLL_MIN_S      = 2;
  localparam int unsigned POLL_MAX_S      = 10;
  localparam int unsigned POLL_DEF_S      = 5;
  localparam int unsigned POLL_DEF_CYC    = POLL_DEF_S * CLK_HZ;
  localparam int unsigned STROBE_NS       = 1000;
  localparam int unsigned CLK_NS          = 25;
  localparam int unsigned STROBE_CYC      = (STROBE_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned SETUP_CYC       = 2;

  // ****************************************
  // widths and reset values
  // ****************************************
  localparam int unsigned NUM_DRIVES      = 7;
  localparam int unsigned NUM_CHANS       = 3;
  localparam int unsigned SYNC_W          = 5;
  localparam logic [2:0]  SEL_IDLE        = 3'h7;
  localparam logic [6:0]  IND_RESET       = 7'h00;

  // ****************************************
  // positions of the synchronised inputs
  // ****************************************
  localparam int unsigned IN_OVERTEMP     = 4;
  localparam int unsigned IN_SUPPLY       = 3;
  localparam int unsigned IN_FAN          = 2;
  localparam int unsigned IN_SILENCE      = 1;
  localparam int unsigned IN_RESCAN       = 0;

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [1:0] {
    SCAN_IDLE  = 2'b00,
    SCAN_SETUP = 2'b01,
    SCAN_STRB  = 2'b10,
    SCAN_HOLD  = 2'b11
  } efs_scan_t;

  typedef struct packed {
    logic overtemp;
    logic supply;
    logic fan;
  } efs_fault_t;

endpackage

// >>> hdl/efs_top.sv
// enclosure fault signals: indicator strobing, alarm, fault inputs, poll tick
// assumes enclosure inputs are asynchronous level lines from a cable
`timescale 1ns/100ps

// How it works
// - controller alone starts each enclosure exchange
// - poll tick every two to ten seconds
// - alarm output high sounds the alarm
// - seven drive fault outputs, high means faulty
// - three channel strobes, low selects channel
// - low temperature line means active fault
// - low supply line means active fault
// - low fan line means active fault
// - latch swap input, then request rescan
// - high output shows fault management running
module efs_top
  import efs_pkg::*;
#(
  parameter int unsigned POLL_CYC = POLL_DEF_CYC
) (
  // clock and reset
  input  wire logic                   clk_sys,
  input  wire logic                   reset_n,
  // controller side
  input  wire logic                   fm_enable,
  input  wire logic                   alarm_on,
  input  wire logic [NUM_DRIVES-1:0]  chan_fault_0,
  input  wire logic [NUM_DRIVES-1:0]  chan_fault_1,
  input  wire logic [NUM_DRIVES-1:0]  chan_fault_2,
  input  wire logic                   silence_ack,
  input  wire logic                   rescan_ack,
  output logic                        poll_tick,
  output efs_fault_t                  fault_status,
  output logic                        silence_pending,
  output logic                        rescan_pending,
  output logic                        rescan_req,
  // enclosure cable
  output logic                        alarm_out,
  output logic [NUM_DRIVES-1:0]       drive_fault_ind,
  output logic [NUM_CHANS-1:0]        chan_select_n,
  output logic                        fault_mgmt_active_out,
  input  wire logic                   overtemp_fault_in,
  input  wire logic                   supply_fault_in,
  input  wire logic                   fan_fault_in,
  input  wire logic                   alarm_silence_req_n,
  input  wire logic                   rescan_req_n
);

  // ****************************************
  // input synchronisers
  // ****************************************
  logic [SYNC_W-1:0] raw_in;
  logic [SYNC_W-1:0] sync1_r;
  logic [SYNC_W-1:0] sync2_r;

  assign raw_in = {overtemp_fault_in, supply_fault_in, fan_fault_in,
                   alarm_silence_req_n, rescan_req_n};

  genvar gi;
  generate
    for (gi = 0; gi < SYNC_W; gi++) begin : g_sync
      always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
          sync1_r[gi] <= 1'b1;
          sync2_r[gi] <= 1'b1;
        end else begin
          sync1_r[gi] <= raw_in[gi];
          sync2_r[gi] <= sync1_r[gi];
        end
      end
    end
  endgenerate

  // ****************************************
  // fault status
  // ****************************************
  logic overtemp_r;
  logic supply_r;
  logic fan_r;

  // cable lines are low active; a fault is held high here
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      overtemp_r <= 1'b0;
    end else begin
      overtemp_r <= ~sync2_r[IN_OVERTEMP];
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      supply_r <= 1'b0;
    end else begin
      supply_r <= ~sync2_r[IN_SUPPLY];
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      fan_r <= 1'b0;
    end else begin
      fan_r <= ~sync2_r[IN_FAN];
    end
  end

  assign fault_status = {overtemp_r, supply_r, fan_r};

  // ****************************************
  // request latches
  // ****************************************
  logic silence_r;
  logic rescan_r;
  logic rescan_pulse_r;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      silence_r <= 1'b0;
    end else if (!sync2_r[IN_SILENCE]) begin
      silence_r <= 1'b1;
    end else if (silence_ack) begin
      silence_r <= 1'b0;
    end
  end

  // set wins over ack, so a swap held low is never lost
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rescan_r <= 1'b0;
    end else if (!sync2_r[IN_RESCAN]) begin
      rescan_r <= 1'b1;
    end else if (rescan_ack) begin
      rescan_r <= 1'b0;
    end
  end

  // pulse once, on the cycle the latch first sets
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rescan_pulse_r <= 1'b0;
    end else begin
      rescan_pulse_r <= !sync2_r[IN_RESCAN] && !rescan_r;
    end
  end

  assign silence_pending = silence_r;
  assign rescan_pending  = rescan_r;
  assign rescan_req      = rescan_pulse_r;

  // ****************************************
  // alarm and active outputs
  // ****************************************
  // alarm held off while a silence request is pending
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      alarm_out <= 1'b0;
    end else begin
      alarm_out <= fm_enable && alarm_on && !silence_r;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      fault_mgmt_active_out <= 1'b0;
    end else begin
      fault_mgmt_active_out <= fm_enable;
    end
  end

  // ****************************************
  // poll timer
  // ****************************************
  logic [31:0] poll_cnt_r;
  logic        poll_wrap;

  assign poll_wrap = (poll_cnt_r == 32'(POLL_CYC - 1));

  // counter runs only while fault management is on
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      poll_cnt_r <= '0;
    end else if (!fm_enable || poll_wrap) begin
      poll_cnt_r <= '0;
    end else begin
      poll_cnt_r <= poll_cnt_r + 32'h1;
    end
  end

  // one-cycle tick on each wrap
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      poll_tick <= 1'b0;
    end else begin
      poll_tick <= fm_enable && poll_wrap;
    end
  end

  // ****************************************
  // indicator strobe sequencer
  // ****************************************
  efs_scan_t             state_r;
  logic [1:0]            chan_r;
  logic [7:0]            cnt_r;
  logic [NUM_DRIVES-1:0] pattern;
  logic                  setup_done;
  logic                  strobe_done;

  // one channel every 44 cycles; a started strobe always completes
  assign setup_done  = (cnt_r == 8'(SETUP_CYC - 1));
  assign strobe_done = (cnt_r == 8'(STROBE_CYC - 1));

  always_comb begin
    case (chan_r)
      2'h0:    pattern = chan_fault_0;
      2'h1:    pattern = chan_fault_1;
      default: pattern = chan_fault_2;
    endcase
  end

  // scan state: load, set up, strobe, release
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= SCAN_IDLE;
    end else begin
      case (state_r)
        SCAN_IDLE: begin
          if (fm_enable) begin
            state_r <= SCAN_SETUP;
          end
        end
        SCAN_SETUP: begin
          if (setup_done) begin
            state_r <= SCAN_STRB;
          end
        end
        SCAN_STRB: begin
          if (strobe_done) begin
            state_r <= SCAN_HOLD;
          end
        end
        SCAN_HOLD: begin
          state_r <= SCAN_IDLE;
        end
        default: begin
          state_r <= SCAN_IDLE;
        end
      endcase
    end
  end

  // phase counter, cleared at every phase change
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      cnt_r <= 8'h00;
    end else if (state_r == SCAN_SETUP && !setup_done) begin
      cnt_r <= cnt_r + 8'h01;
    end else if (state_r == SCAN_STRB && !strobe_done) begin
      cnt_r <= cnt_r + 8'h01;
    end else begin
      cnt_r <= 8'h00;
    end
  end

  // channel advances once the strobe is released
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      chan_r <= 2'h0;
    end else if (state_r == SCAN_HOLD) begin
      chan_r <= (chan_r == 2'h2) ? 2'h0 : chan_r + 2'h1;
    end
  end

  // pattern loads only while every strobe is high
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      drive_fault_ind <= IND_RESET;
    end else if (state_r == SCAN_IDLE && fm_enable) begin
      drive_fault_ind <= pattern;
    end
  end

  // strobe low for the strobe phase, idle otherwise
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      chan_select_n <= SEL_IDLE;
    end else if (state_r == SCAN_SETUP && setup_done) begin
      chan_select_n <= ~(3'h1 << chan_r);
    end else if (state_r == SCAN_STRB && strobe_done) begin
      chan_select_n <= SEL_IDLE;
    end else if (state_r == SCAN_IDLE) begin
      chan_select_n <= SEL_IDLE;
    end
  end

endmodule

// >>> verification/efs_encl_model.sv
// enclosure model: fault lines, request lines, indicator capture
// lines idle high as with cable pull-ups
`timescale 1ns/100ps
module efs_encl_model
  import efs_pkg::*;
(
  // clock and scenario commands, high = assert
  input wire logic                             clk_sys,
  input wire efs_fault_t                       fault_cmd,
  input wire logic                             sil_cmd,
  input wire logic                             resc_cmd,
  // cable
  input wire logic [NUM_DRIVES-1:0]            drive_fault_ind,
  input wire logic [NUM_CHANS-1:0]             chan_select_n,
  output logic                                 overtemp_fault_in,
  output logic                                 supply_fault_in,
  output logic                                 fan_fault_in,
  output logic                                 alarm_silence_req_n,
  output logic                                 rescan_req_n,
  output logic [NUM_CHANS-1:0][NUM_DRIVES-1:0] seen
);
  assign overtemp_fault_in = !fault_cmd.overtemp;
  assign supply_fault_in = !fault_cmd.supply;
  assign fan_fault_in = !fault_cmd.fan;
  assign alarm_silence_req_n = !sil_cmd;
  assign rescan_req_n = !resc_cmd;
  always_ff @(posedge clk_sys) begin
    for (int c = 0; c < NUM_CHANS; c++) begin
      if (!chan_select_n[c]) begin
        seen[c] <= drive_fault_ind;
      end
    end
  end
endmodule

// >>> verification/efs_top_monitor.sv
// checker: assertions on efs_top ports
// bound into every efs_top instance
`timescale 1ns/100ps
module efs_top_monitor
  import efs_pkg::*;
(
  // clock and reset
  input wire logic                  clk_sys,
  input wire logic                  reset_n,
  // controller side
  input wire logic                  fm_enable,
  input wire logic                  alarm_on,
  input wire logic                  poll_tick,
  input wire efs_fault_t            fault_status,
  input wire logic                  silence_pending,
  input wire logic                  rescan_pending,
  input wire logic                  rescan_req,
  // enclosure cable
  input wire logic                  alarm_out,
  input wire logic [NUM_DRIVES-1:0] drive_fault_ind,
  input wire logic [NUM_CHANS-1:0]  chan_select_n,
  input wire logic                  fault_mgmt_active_out,
  input wire logic                  overtemp_fault_in,
  input wire logic                  supply_fault_in,
  input wire logic                  fan_fault_in,
  input wire logic                  alarm_silence_req_n,
  input wire logic                  rescan_req_n
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  sequence s_low(x);
    $fell(x) ##1 !x [*2];
  endsequence
  chk_strobe_single: assert property ($onehot0(~chan_select_n))
    else $error("more than one strobe low");
  chk_pattern_held: assert property (chan_select_n != SEL_IDLE |-> $stable(drive_fault_ind))
    else $error("pattern moved under strobe");
  chk_temp_seen: assert property (s_low(overtemp_fault_in) |-> ##[0:2] fault_status.overtemp)
    else $error("temperature fault missed");
  chk_supply_seen: assert property (s_low(supply_fault_in) |-> ##[0:2] fault_status.supply)
    else $error("supply fault missed");
  chk_fan_seen: assert property (s_low(fan_fault_in) |-> ##[0:2] fault_status.fan)
    else $error("fan fault missed");
  chk_silence_latch: assert property (s_low(alarm_silence_req_n) |-> ##[0:2] silence_pending)
    else $error("silence request not latched");
  chk_alarm_quiet: assert property (silence_pending |=> !alarm_out)
    else $error("alarm sounds while silenced");
  chk_alarm_cause: assert property (alarm_out |-> $past(fm_enable && alarm_on))
    else $error("alarm without request");
  chk_rescan_latch: assert property (s_low(rescan_req_n) |-> ##[0:2] rescan_pending)
    else $error("rescan request not latched");
  chk_rescan_once: assert property (rescan_req |=> !rescan_req && rescan_pending)
    else $error("rescan pulse wrong");
  chk_active_track: assert property (!$stable(fm_enable) |=> fault_mgmt_active_out == $past(fm_enable))
    else $error("active output not tracking enable");
  chk_poll_pulse: assert property (poll_tick |-> $past(fm_enable) ##1 !poll_tick)
    else $error("poll tick wrong");
endmodule

bind efs_top efs_top_monitor u_mon (
  .clk_sys, .reset_n, .fm_enable, .alarm_on, .poll_tick, .fault_status,
  .silence_pending, .rescan_pending, .rescan_req, .alarm_out, .drive_fault_ind,
  .chan_select_n, .fault_mgmt_active_out, .overtemp_fault_in, .supply_fault_in,
  .fan_fault_in, .alarm_silence_req_n, .rescan_req_n);

// >>> verification/test_efs_top.sv
// testbench for efs_top with enclosure model
// self-checking, one clock, fixed stimulus
`timescale 1ns/100ps
module test_efs_top;
  import efs_pkg::*;
  logic                  clk_sys = 1'b0, reset_n = 1'b0, fm_enable = 1'b0, alarm_on = 1'b0;
  logic                  silence_ack = 1'b0, rescan_ack = 1'b0, sil = 1'b0, resc = 1'b0;
  logic [NUM_DRIVES-1:0] chan_fault_0 = 7'h00, chan_fault_1 = 7'h00, chan_fault_2 = 7'h00;
  efs_fault_t            fcmd = '0, fault_status;
  logic                  poll_tick, silence_pending, rescan_pending, rescan_req, alarm_out;
  logic                  fault_mgmt_active_out, overtemp_fault_in, supply_fault_in;
  logic                  fan_fault_in, alarm_silence_req_n, rescan_req_n;
  logic [NUM_DRIVES-1:0] drive_fault_ind;
  logic [NUM_CHANS-1:0]  chan_select_n;
  logic [NUM_CHANS-1:0][NUM_DRIVES-1:0] seen;
  int                    n_errors = 0, samples_checked = 0, n;

  always #12.5 clk_sys = ~clk_sys;

  efs_top #(.POLL_CYC(50)) dut (.clk_sys, .reset_n, .fm_enable, .alarm_on, .chan_fault_0,
    .chan_fault_1, .chan_fault_2, .silence_ack, .rescan_ack, .poll_tick, .fault_status,
    .silence_pending, .rescan_pending, .rescan_req, .alarm_out, .drive_fault_ind,
    .chan_select_n, .fault_mgmt_active_out, .overtemp_fault_in, .supply_fault_in,
    .fan_fault_in, .alarm_silence_req_n, .rescan_req_n);
  efs_encl_model u_encl (.clk_sys, .fault_cmd(fcmd), .sil_cmd(sil), .resc_cmd(resc),
    .drive_fault_ind, .chan_select_n, .overtemp_fault_in, .supply_fault_in, .fan_fault_in,
    .alarm_silence_req_n, .rescan_req_n, .seen);

  task automatic w(input int k);
    repeat (k) @(posedge clk_sys);
    #1;
  endtask
  task automatic chk(input logic [6:0] got, input logic [6:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic t_strobe();
    @(posedge clk_sys);
    chan_fault_0 <= 7'h41;
    chan_fault_1 <= 7'h2a;
    chan_fault_2 <= 7'h15;
    fm_enable <= 1'b1;
    w(150);
    chk(seen[0], 7'h41);
    chk(seen[1], 7'h2a);
    chk(seen[2], 7'h15);
    chk(7'(fault_mgmt_active_out), 7'h01);
  endtask
  task automatic t_faults();
    for (int i = 0; i < 3; i++) begin
      @(posedge clk_sys);
      fcmd <= 3'h4 >> i;
      w(6);
      chk(7'(fault_status), 7'(3'h4 >> i));
      @(posedge clk_sys);
      fcmd <= '0;
      w(6);
      chk(7'(fault_status), 7'h00);
    end
  endtask
  task automatic t_alarm();
    @(posedge clk_sys);
    alarm_on <= 1'b1;
    w(3);
    chk(7'(alarm_out), 7'h01);
    @(posedge clk_sys);
    sil <= 1'b1;
    repeat (3) @(posedge clk_sys);
    sil <= 1'b0;
    w(4);
    chk(7'({silence_pending, alarm_out}), 7'h02);
    @(posedge clk_sys);
    silence_ack <= 1'b1;
    @(posedge clk_sys);
    silence_ack <= 1'b0;
    w(3);
    chk(7'({silence_pending, alarm_out}), 7'h01);
    @(posedge clk_sys);
    alarm_on <= 1'b0;
    w(2);
    chk(7'(alarm_out), 7'h00);
  endtask
  task automatic t_rescan();
    n = 0;
    for (int i = 0; i < 10; i++) begin
      @(posedge clk_sys);
      resc <= (i < 3);
      #1;
      n += rescan_req;
    end
    chk({n[5:0], rescan_pending}, 7'h03);
    @(posedge clk_sys);
    rescan_ack <= 1'b1;
    @(posedge clk_sys);
    rescan_ack <= 1'b0;
    w(2);
    chk(7'(rescan_pending), 7'h00);
  endtask
  task automatic t_poll();
    n = 0;
    for (int i = 0; i < 100; i++) begin
      w(1);
      n += poll_tick;
    end
    chk(n[6:0], 7'h02);
    @(posedge clk_sys);
    fm_enable <= 1'b0;
    n = 0;
    for (int i = 0; i < 100; i++) begin
      w(1);
      n += poll_tick;
    end
    chk(n[6:0], 7'h00);
    chk(7'({fault_mgmt_active_out, chan_select_n}), 7'h07);
  endtask
  task automatic conclude();
    if (n_errors == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    repeat (8) @(posedge clk_sys);
    reset_n <= 1'b1;
    t_strobe();
    t_faults();
    t_alarm();
    t_rescan();
    t_poll();
    conclude();
  end
  initial begin
    #500000;
    n_errors++;
    conclude();
  end
endmodule
